// ### core/adc_seq_pkg.sv
package adc_seq_pkg;
  localparam int NUM_CH = 16;
  localparam int RES_W = 10;
  localparam int ADDR_W = 8;
  // Register byte addresses
  localparam logic [7:0] OFS_CTRL_FIRST = 8'h00;
  localparam logic [7:0] OFS_CTRL_SECOND = 8'h04;
  localparam logic [7:0] OFS_SEL_LOW = 8'h08;
  localparam logic [7:0] OFS_SEL_HIGH = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_SEQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_RESULT_BASE = 8'h40;
  localparam logic [7:0] OFS_RESULT_STEP = 8'h08;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h04;
  // Field positions
  localparam int BIT_LOOP = 0;
  localparam int BIT_RUN = 0;
  localparam int BIT_IRQ_SCAN_DONE = 0;
  localparam int BIT_IRQ_EMPTY_START = 1;
  localparam int IRQ_W = 2;
  localparam int RES_LOW_POS = 6;
  // Reset values
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [IRQ_W-1:0] RST_MASK = 2'h0;
  localparam logic [RES_W-1:0] RST_RESULT = 10'h000;

  typedef struct packed {
    logic start;
    logic [3:0] channel;
  } conv_req_t;

  typedef struct packed {
    logic done;
    logic [RES_W-1:0] value;
  } conv_ans_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PICK = 4'b0010,
    ST_CONV = 4'b0100,
    ST_HOLD = 4'b1000
  } seq_state_t;
endpackage : adc_seq_pkg

// ### core/channel_picker.sv
module channel_picker
  import adc_seq_pkg::*;
#(
  parameter int N = NUM_CH
) (
  input wire logic [N-1:0] i_set,
  input wire logic [3:0] i_from,
  input wire logic i_any_from,
  output logic o_found,
  output logic [3:0] o_channel,
  output logic o_is_last
);
  // Lowest enabled channel at or above i_from (or from 0 when i_any_from)
  always_comb begin
    o_found = 1'b0;
    o_channel = 4'h0;
    o_is_last = 1'b1;
    for (int k = N - 1; k >= 0; k--) begin
      if (i_set[k] && (i_any_from || k >= int'(i_from))) begin
        o_found = 1'b1;
        o_channel = 4'(k);
      end
    end
    for (int k = 0; k < N; k++) begin
      if (i_set[k] && o_found && k > int'(o_channel)) begin
        o_is_last = 1'b0;
      end
    end
  end
endmodule : channel_picker

// ### core/result_bank.sv
module result_bank
  import adc_seq_pkg::*;
#(
  parameter int N = NUM_CH
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr,
  input wire logic [3:0] i_channel,
  input wire logic [RES_W-1:0] i_value,
  input wire logic [3:0] i_rd_channel,
  output logic [RES_W-1:0] o_rd_value
);
  logic [RES_W-1:0] mem_r [N];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int k = 0; k < N; k++) begin
        mem_r[k] <= RST_RESULT;
      end
    end else if (i_wr) begin
      mem_r[i_channel] <= i_value;
    end
  end

  assign o_rd_value = mem_r[i_rd_channel];
endmodule : result_bank

// ### core/sar_adc_scan_sequencer.sv
//Contract
//- Upper select register holds eight enable bits for channels 8-15, reset zero.
//- Enabled channels are converted in ascending channel order.
//- Results land only in the converted channel's own registers.
//- Start with no channel selected converts nothing, raises nothing, run stays one; the code sets the empty-start status bit (bit 1) once.
//- Writing one to run starts converting at the lowest enabled channel.
//- After the highest enabled channel is stored, raise scan-done once.
//- At scan end clear run if loop is zero, else restart the scan.
//- Selection is captured at scan start and held until scan-done.
//- Result split: high holds bits 9..2, low holds bits 1..0 in bits 7..6.
//- Writing zero to run stops conversion; run resets to zero.
//
// Chosen here: the APB register port and the register addresses.
module sar_adc_scan_sequencer
  import adc_seq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_conv_power,
  output logic o_conv_start,
  output logic [3:0] o_conv_channel,
  input wire logic i_conv_done,
  input wire logic [RES_W-1:0] i_conv_value,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic setup_phase;
  logic wr_en;
  logic loop_r;
  logic run_r;
  logic [7:0] sel_low_r;
  logic [7:0] sel_high_r;
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [NUM_CH-1:0] captured_r;
  logic [3:0] cur_ch_r;
  seq_state_t state_r;
  seq_state_t state_nxt;
  conv_req_t req_r;
  conv_ans_t ans;
  logic [RES_W-1:0] rd_value;
  logic [3:0] rd_channel;
  logic is_result_addr;
  logic pick_found;
  logic [3:0] pick_ch;
  logic pick_last;
  logic last_r;
  logic store_pulse;
  logic scan_end;
  logic empty_start;
  logic run_wr_one;
  logic run_wr_zero;

  function automatic logic lane0_write(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    lane0_write = (a == ofs) && i_pstrb[0];
  endfunction : lane0_write

  // Single-cycle access: ready is registered from the setup cycle so access phase ends at once
  assign setup_phase = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && i_pwrite && o_pready;
  assign is_result_addr = (i_paddr >= OFS_RESULT_BASE) && (i_paddr[1:0] == 2'b00);
  assign rd_channel = 4'((i_paddr - OFS_RESULT_BASE) >> 3);
  assign ans.done = i_conv_done;
  assign ans.value = i_conv_value;
  assign run_wr_one = wr_en && lane0_write(i_paddr, OFS_CTRL_SECOND) && i_pwdata[BIT_RUN];
  assign run_wr_zero = wr_en && lane0_write(i_paddr, OFS_CTRL_SECOND) && !i_pwdata[BIT_RUN];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= setup_phase;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (setup_phase) begin
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
      if (i_pwrite) begin
        o_pslverr <= !(i_paddr == OFS_CTRL_FIRST || i_paddr == OFS_CTRL_SECOND ||
                       i_paddr == OFS_SEL_LOW || i_paddr == OFS_SEL_HIGH ||
                       i_paddr == OFS_IRQ_STATUS || i_paddr == OFS_IRQ_MASK);
      end else if (is_result_addr && i_paddr < OFS_RESULT_BASE + 8'(NUM_CH * 8)) begin
        if (i_paddr[2]) begin
          o_prdata <= {24'h00_0000, rd_value[RES_W-1:2]};
        end else begin
          o_prdata <= {24'h00_0000, rd_value[1:0], 6'h00};
        end
      end else begin
        unique case (i_paddr)
          OFS_CTRL_FIRST: o_prdata <= {31'h0000_0000, loop_r};
          OFS_CTRL_SECOND: o_prdata <= {31'h0000_0000, run_r};
          OFS_SEL_LOW: o_prdata <= {24'h00_0000, sel_low_r};
          OFS_SEL_HIGH: o_prdata <= {24'h00_0000, sel_high_r};
          OFS_IRQ_STATUS: o_prdata <= {30'h0000_0000, irq_status_r};
          OFS_IRQ_MASK: o_prdata <= {30'h0000_0000, irq_mask_r};
          OFS_SEQ_STATUS: o_prdata <= {23'h00_0000, state_r != ST_IDLE, 4'h0, cur_ch_r};
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      loop_r <= 1'b0;
      sel_low_r <= RST_SEL;
      sel_high_r <= RST_SEL;
      irq_mask_r <= RST_MASK;
    end else if (wr_en && i_pstrb[0]) begin
      if (i_paddr == OFS_CTRL_FIRST) loop_r <= i_pwdata[BIT_LOOP];
      if (i_paddr == OFS_SEL_LOW) sel_low_r <= i_pwdata[7:0];
      if (i_paddr == OFS_SEL_HIGH) sel_high_r <= i_pwdata[7:0];
      if (i_paddr == OFS_IRQ_MASK) irq_mask_r <= i_pwdata[IRQ_W-1:0];
    end
  end

  // Run bit: software write, cleared by hardware at single-scan end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      run_r <= 1'b0;
    end else if (run_wr_one) begin
      run_r <= 1'b1;
    end else if (run_wr_zero) begin
      run_r <= 1'b0;
    end else if (scan_end && !loop_r) begin
      run_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan sequencer
  channel_picker #(.N(NUM_CH)) u_pick (
    .i_set(captured_r),
    .i_from(cur_ch_r),
    .i_any_from(state_r == ST_IDLE || state_r == ST_HOLD),
    .o_found(pick_found),
    .o_channel(pick_ch),
    .o_is_last(pick_last)
  );

  result_bank #(.N(NUM_CH)) u_bank (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr(store_pulse),
    .i_channel(cur_ch_r),
    .i_value(ans.value),
    .i_rd_channel(rd_channel),
    .o_rd_value(rd_value)
  );

  assign store_pulse = (state_r == ST_CONV) && ans.done && run_r && !run_wr_zero;
  assign scan_end = store_pulse && last_r;
  // Empty selection parks in HOLD: converter powered, nothing converted
  assign empty_start = (state_r == ST_PICK) && !pick_found;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (run_r) state_nxt = ST_PICK;
      ST_PICK: state_nxt = pick_found ? ST_CONV : ST_HOLD;
      ST_CONV: if (store_pulse) state_nxt = (last_r && !loop_r) ? ST_IDLE : ST_PICK;
      ST_HOLD: if ((captured_r | {sel_high_r, sel_low_r}) != '0) state_nxt = ST_PICK;
      default: state_nxt = ST_IDLE;
    endcase
    if (!run_r || run_wr_zero) state_nxt = ST_IDLE;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Capture selection at scan start; held until scan end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      captured_r <= '0;
    end else if ((state_r == ST_IDLE && run_r) || state_r == ST_HOLD || scan_end) begin
      captured_r <= {sel_high_r, sel_low_r};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cur_ch_r <= 4'h0;
      last_r <= 1'b0;
    end else if (state_r == ST_PICK && pick_found) begin
      cur_ch_r <= pick_ch;
      last_r <= pick_last;
    end else if (store_pulse) begin
      // Next search starts above the stored channel; wraps to 0 on scan end
      cur_ch_r <= last_r ? 4'h0 : 4'(cur_ch_r + 4'h1);
    end else if (state_r == ST_IDLE || state_r == ST_HOLD) begin
      // A stopped scan leaves a stale channel; a new search must begin at 0
      cur_ch_r <= 4'h0;
    end
  end

  // Converter handshake
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      req_r <= '0;
    end else begin
      req_r.start <= (state_r == ST_PICK) && pick_found && run_r && !run_wr_zero;
      if (state_r == ST_PICK && pick_found) req_r.channel <= pick_ch;
    end
  end

  assign o_conv_start = req_r.start;
  assign o_conv_channel = req_r.channel;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_conv_power <= 1'b0;
    end else begin
      o_conv_power <= run_r && !run_wr_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: set wins over write-one-to-clear
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      irq_status_r <= '0;
    end else begin
      for (int k = 0; k < IRQ_W; k++) begin
        if ((k == BIT_IRQ_SCAN_DONE && scan_end) || (k == BIT_IRQ_EMPTY_START && empty_start)) begin
          irq_status_r[k] <= 1'b1;
        end else if (wr_en && lane0_write(i_paddr, OFS_IRQ_STATUS) && i_pwdata[k]) begin
          irq_status_r[k] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status_r & irq_mask_r);
    end
  end
endmodule : sar_adc_scan_sequencer

// ### tb/adc_core_model.sv
module adc_core_model
  import adc_seq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic [3:0] i_channel,
  input wire logic [3:0] i_wait,
  output logic o_done,
  output logic [RES_W-1:0] o_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_r;
  logic [3:0] cnt_r;
  initial begin
    o_done = 1'b0;
    o_value = 10'h000;
    busy_r = 1'b0;
    cnt_r = 4'h0;
  end
  ////////////////////////////////////////////////////////////
  // Value toggles outside done so a stale sample never matches
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    o_value <= ~o_value;
    if (i_start) begin
      busy_r <= 1'b1;
      cnt_r <= i_wait;
    end else if (busy_r && cnt_r == 4'h0) begin
      busy_r <= 1'b0;
      o_done <= 1'b1;
      o_value <= {i_channel, 6'h2B};
    end else if (busy_r) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule : adc_core_model

// ### tb/sar_adc_scan_sequencer_sva.sv
module sar_adc_scan_sequencer_sva
  import adc_seq_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_conv_power,
  input wire logic o_conv_start,
  input wire logic [3:0] o_conv_channel,
  input wire logic i_conv_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  logic run_wr;
  assign run_wr = i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0] && i_paddr == OFS_CTRL_SECOND;
  ////////////////////////////////////////////////////////////
  property p_start_pulse; o_conv_start |=> !o_conv_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start held");
  property p_start_power; o_conv_start |-> o_conv_power; endproperty
  a_start_power: assert property (p_start_power) else $error("start unpowered");
  property p_chan_hold; o_conv_start |=> $stable(o_conv_channel) [*2]; endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
  property p_ready; i_psel && !i_penable |=> o_pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_run_on; run_wr && i_pwdata[0] |-> ##[1:2] o_conv_power; endproperty
  a_run_on: assert property (p_run_on) else $error("power missing");
  property p_run_off; run_wr && !i_pwdata[0] |-> ##[1:2] !o_conv_power; endproperty
  a_run_off: assert property (p_run_off) else $error("power stuck");
  property p_gap; i_conv_done && o_conv_power |=> !o_conv_start; endproperty
  a_gap: assert property (p_gap) else $error("start too soon");
  property p_ro; i_psel && !i_penable && i_pwrite && i_paddr >= OFS_RESULT_BASE |=> o_pslverr; endproperty
  a_ro: assert property (p_ro) else $error("result write taken");
endmodule : sar_adc_scan_sequencer_sva

// ### tb/test_sar_adc_scan_sequencer.sv
module test_sar_adc_scan_sequencer;
  import adc_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_sys_rst, psel, pen, pw, rdy, serr, pwr_on, start, done, irq, er;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] ch, slow;
  logic [RES_W-1:0] val;
  logic [3:0] seen[$];
  int err_total, comparisons, starts, k;
  sar_adc_scan_sequencer dut(.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pw), .i_paddr(addr), .i_pwdata(wdata), .i_pstrb(4'hF), .o_prdata(rdata), .o_pready(rdy),
    .o_pslverr(serr), .o_conv_power(pwr_on), .o_conv_start(start), .o_conv_channel(ch),
    .i_conv_done(done), .i_conv_value(val), .o_irq(irq));
  adc_core_model core(.i_clk(i_clk), .i_start(start), .i_channel(ch), .i_wait(slow), .o_done(done),
    .o_value(val));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (start) begin
    seen.push_back(ch);
    starts++;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Idles one edge after release so back-to-back calls never double-drive
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pw <= w;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do @(posedge i_clk); while (rdy !== 1'b1);
    rd = rdata;
    er = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clk);
  endtask : apb
  task automatic chk_res(input logic [3:0] c, input logic hit);
    logic [9:0] v;
    v = hit ? {c, 6'h2B} : 10'h000;
    apb(1'b0, OFS_RESULT_BASE + {1'b0, c, 3'h0}, 0);
    chk(rd, {24'h0, v[1:0], 6'h00}, "result low");
    apb(1'b0, OFS_RESULT_BASE + {1'b0, c, 3'h0} + OFS_RESULT_HIGH, 0);
    chk(rd, {24'h0, v[9:2]}, "result high");
  endtask : chk_res
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////
  initial begin
    {i_sys_rst, psel, pen, pw, addr, wdata, slow} = {1'b1, 47'h0};
    {err_total, comparisons, starts} = 0;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    // Fast clock taken as settled before any start
    apb(1'b0, OFS_SEL_HIGH, 0); chk(rd, 0, "select high");
    apb(1'b0, OFS_CTRL_SECOND, 0); chk(rd, 0, "run bit");
    apb(1'b1, OFS_SEL_LOW, 32'h09);
    apb(1'b1, OFS_SEL_HIGH, 32'h02);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    slow <= 4'h3;
    apb(1'b1, OFS_CTRL_SECOND, 32'h1);
    apb(1'b1, OFS_SEL_LOW, 32'h20);
    apb(1'b1, OFS_SEL_HIGH, 32'h00);
    do @(posedge i_clk); while (irq !== 1'b1);
    chk({20'h0, seen[0], seen[1], seen[2]}, 32'h039, "scan order");
    chk(32'(seen.size()), 3, "start count");
    apb(1'b0, OFS_CTRL_SECOND, 0); chk(rd, 0, "run after scan");
    chk(32'(pwr_on), 0, "power after scan");
    chk_res(4'h0, 1'b1); chk_res(4'h3, 1'b1); chk_res(4'h9, 1'b1);
    chk_res(4'h5, 1'b0); chk_res(4'h1, 1'b0);
    apb(1'b0, OFS_IRQ_STATUS, 0); chk(rd, 1, "irq status");
    apb(1'b1, OFS_IRQ_STATUS, 1);
    repeat (2) @(posedge i_clk);
    chk(32'(irq), 0, "irq cleared");
    apb(1'b1, OFS_IRQ_MASK, 0);
    apb(1'b1, OFS_SEL_HIGH, 32'h80);
    apb(1'b1, OFS_CTRL_FIRST, 1);
    slow <= 4'h0;
    k = starts;
    apb(1'b1, OFS_CTRL_SECOND, 1);
    do @(posedge i_clk); while (starts < k + 5);
    apb(1'b0, OFS_CTRL_SECOND, 0); chk(rd, 1, "run looping");
    apb(1'b0, OFS_IRQ_STATUS, 0); chk(rd, 1, "loop status");
    chk(32'(irq), 0, "irq masked");
    apb(1'b1, OFS_IRQ_MASK, 1);
    repeat (2) @(posedge i_clk);
    chk(32'(irq), 1, "irq unmasked");
    apb(1'b1, OFS_CTRL_SECOND, 0);
    repeat (2) @(posedge i_clk);
    chk(32'(pwr_on), 0, "power stopped");
    apb(1'b1, OFS_IRQ_STATUS, 1);
    chk_res(4'hF, 1'b1);
    apb(1'b1, OFS_CTRL_FIRST, 0);
    apb(1'b1, OFS_SEL_LOW, 0);
    apb(1'b1, OFS_SEL_HIGH, 0);
    k = starts;
    apb(1'b1, OFS_CTRL_SECOND, 1);
    repeat (20) @(posedge i_clk);
    apb(1'b0, OFS_CTRL_SECOND, 0); chk(rd, 1, "run empty");
    chk(32'(starts - k), 0, "empty starts");
    chk(32'(pwr_on), 1, "power empty");
    apb(1'b0, OFS_IRQ_STATUS, 0); chk({31'h0, rd[0]}, 0, "empty done");
    apb(1'b1, OFS_SEL_LOW, 32'h01);
    do @(posedge i_clk); while (starts == k);
    chk(32'(seen[$]), 0, "restart channel");
    apb(1'b1, OFS_CTRL_SECOND, 0);
    apb(1'b0, 8'h3C, 0); chk({31'h0, er}, 1, "unmapped");
    apb(1'b1, OFS_RESULT_BASE, 32'hFF); chk({31'h0, er}, 1, "result write");
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    err_total++;
    complete_run;
  end
endmodule : test_sar_adc_scan_sequencer
bind sar_adc_scan_sequencer sar_adc_scan_sequencer_sva chk_i(.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_pstrb(i_pstrb), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_conv_power(o_conv_power),
  .o_conv_start(o_conv_start), .o_conv_channel(o_conv_channel), .i_conv_done(i_conv_done));
